/* File: core/sleep_ctrl.sv */
// Sleep mode controller: gates CPU, I/O, memory and oscillator enables
`include "sleep_defines.svh"
`default_nettype none

module sleep_ctrl
#(
  parameter int N_WAKE = 4
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [2:0]        mode_sel,
  input  wire logic              sleep_en,
  input  wire logic              sleep_req,
  input  wire logic [N_WAKE-1:0] wake_src,
  input  wire logic [N_WAKE-1:0] wake_mask,
  output logic                   cpu_clk_en,
  output logic                   io_clk_en,
  output logic                   sram_clk_en,
  output logic                   irq_clk_en,
  output logic                   adc_clk_en,
  output logic                   osc_en,
  output logic                   async_tmr_en,
  output logic                   sleeping,
  output logic [2:0]             sleep_mode
);
  import sleep_pkg::*;

  mode_if dec_bus ();

  logic         [N_WAKE-1:0] s1_q;
  logic         [N_WAKE-1:0] s1_d;
  logic         [N_WAKE-1:0] s2_q;
  logic         [N_WAKE-1:0] s2_d;
  logic                      wake_hit;
  logic                      enter;
  sleep_state_t              state_q;
  sleep_state_t              state_d;
  clk_en_t                   en_q;
  clk_en_t                   en_d;
  logic         [2:0]        mode_q;
  logic         [2:0]        mode_d;

  sleep_mode_decode i_sleep_mode_decode
  (
    .m (dec_bus.dec)
  );

  assign dec_bus.mode = mode_sel;

  // Wake pins are asynchronous: two flops per bit before any use
  genvar gi;
  generate
    for (gi = 0; gi < N_WAKE; gi++)
    begin : g_sync
      always_comb
      begin
        s1_d[gi] = wake_src[gi];
        s2_d[gi] = s1_q[gi];
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= s1_d[gi];
          s2_q[gi] <= s2_d[gi];
        end
      end
    end
  endgenerate

  assign wake_hit = |(s2_q & wake_mask);

  // A wake already pending would undo the sleep at once, so it blocks entry
  assign enter = sleep_req && sleep_en && dec_bus.valid && !wake_hit;

  always_comb
  begin
    state_d = state_q;
    en_d    = en_q;
    mode_d  = mode_q;
    case (state_q)
      ST_ACTIVE:
      begin
        if (enter)
        begin
          state_d = ST_SLEEP;
          en_d    = dec_bus.en;
          mode_d  = mode_sel;
        end
      end
      ST_SLEEP:
      begin
        // Mode select changes are ignored until the next wake
        if (wake_hit)
        begin
          state_d = ST_ACTIVE;
          en_d    = `EN_ALL;
        end
      end
      default:
      begin
        state_d = ST_ACTIVE;
        en_d    = `EN_ALL;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_ACTIVE;
      en_q    <= `EN_ALL;
      mode_q  <= `RST_MODE;
    end
    else
    begin
      state_q <= state_d;
      en_q    <= en_d;
      mode_q  <= mode_d;
    end
  end

  assign cpu_clk_en   = en_q.cpu;
  assign io_clk_en    = en_q.io;
  assign sram_clk_en  = en_q.sram;
  assign irq_clk_en   = en_q.irq;
  assign adc_clk_en   = en_q.adc;
  assign osc_en       = en_q.osc;
  assign async_tmr_en = en_q.async_tmr;
  assign sleeping     = (state_q == ST_SLEEP);
  assign sleep_mode   = mode_q;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  sequence enter_s(logic [2:0] m);
    state_q == ST_ACTIVE && sleep_req && sleep_en && !wake_hit && mode_sel == m;
  endsequence

  sequence held_s;
    state_q == ST_SLEEP && !wake_hit;
  endsequence

  sequence awake_s;
    !sleeping && cpu_clk_en && io_clk_en && sram_clk_en && irq_clk_en && adc_clk_en && osc_en && async_tmr_en;
  endsequence

  // Pin steady for three samples: two sync stages, then the state step
  sequence pin_held_s;
    sleeping && (wake_src & wake_mask) != '0 ##1 $stable(wake_src & wake_mask) [*2];
  endsequence

  idle_gating_a: assert property (
    enter_s(`MODE_IDLE) |=> sleeping && !cpu_clk_en && sram_clk_en && io_clk_en && irq_clk_en)
    else $error("Idle entry did not stop only the CPU clock");

  pdown_gating_a: assert property (
    enter_s(`MODE_PDOWN) |=> sleeping && en_q == `EN_PDOWN)
    else $error("Power-down left an enable on");

  psave_gating_a: assert property (
    enter_s(`MODE_PSAVE) |=> sleeping && async_tmr_en && !osc_en && !cpu_clk_en && !io_clk_en)
    else $error("Power-save did not keep only the asynchronous timer");

  adc_nr_gating_a: assert property (
    enter_s(`MODE_ADC_NR) |=> sleeping && adc_clk_en && async_tmr_en && !cpu_clk_en && !io_clk_en)
    else $error("ADC noise reduction gating wrong");

  standby_gating_a: assert property (
    enter_s(`MODE_STANDBY) |=> sleeping && osc_en && !async_tmr_en && !cpu_clk_en && !sram_clk_en)
    else $error("Standby did not keep only the oscillator");

  ext_standby_a: assert property (
    enter_s(`MODE_EXT_STANDBY) |=> sleeping && osc_en && async_tmr_en && !cpu_clk_en && !io_clk_en)
    else $error("Extended standby gating wrong");

  reserved_refused_a: assert property (
    state_q == ST_ACTIVE && sleep_req && (mode_sel == 3'h4 || mode_sel == 3'h5) |=> awake_s)
    else $error("Unused mode code entered sleep");

  sleep_holds_a: assert property (
    held_s |=> sleeping && $stable(en_q) && $stable(sleep_mode))
    else $error("Sleep state changed without a wake event");

  wake_restore_a: assert property (
    sleeping && wake_hit |=> awake_s)
    else $error("Wake event did not restore all enables");

  pin_wake_a: assert property (
    pin_held_s |-> ##1 !sleeping)
    else $error("Held wake pin did not wake within three cycles");

  // Entering with a wake already synchronised would bounce straight back
  pending_block_a: assert property (
    state_q == ST_ACTIVE && sleep_req && wake_hit |=> awake_s)
    else $error("Sleep entered with an enabled wake pending");

  en_refused_a: assert property (
    state_q == ST_ACTIVE && sleep_req && !sleep_en |=> awake_s)
    else $error("Sleep entered while sleep was not allowed");

  entry_mode_a: assert property (
    enter |=> sleeping && sleep_mode == $past(mode_sel))
    else $error("Entered mode code not latched");

endmodule // sleep_ctrl

`default_nettype wire

/* File: core/sleep_defines.svh */
// Mode codes, enable patterns and reset values of the sleep controller
`ifndef SLEEP_DEFINES_SVH
`define SLEEP_DEFINES_SVH

// Mode select codes; 3'h4 and 3'h5 are unused and refuse sleep
`define MODE_IDLE        3'h0
`define MODE_ADC_NR      3'h1
`define MODE_PDOWN       3'h2
`define MODE_PSAVE       3'h3
`define MODE_STANDBY     3'h6
`define MODE_EXT_STANDBY 3'h7

// Enable bit positions, MSB first: cpu io sram irq adc osc async
`define EN_CPU_BIT       6
`define EN_IO_BIT        5
`define EN_SRAM_BIT      4
`define EN_IRQ_BIT       3
`define EN_ADC_BIT       2
`define EN_OSC_BIT       1
`define EN_ASYNC_BIT     0

// Enable patterns per mode
`define EN_ALL           7'h7F
`define EN_IDLE          7'h3F
`define EN_ADC_NR        7'h0F
`define EN_PDOWN         7'h00
`define EN_PSAVE         7'h01
`define EN_STANDBY       7'h02
`define EN_EXT_STANDBY   7'h03

// Reset mode code and synchroniser depth
`define RST_MODE         3'h0
`define SYNC_STAGES      2

`endif

/* File: core/sleep_pkg.sv */
// Types shared by the sleep controller modules
`default_nettype none

package sleep_pkg;

  typedef struct packed {
    logic cpu;
    logic io;
    logic sram;
    logic irq;
    logic adc;
    logic osc;
    logic async_tmr;
  } clk_en_t;

  typedef enum logic [0:0] {
    ST_ACTIVE,
    ST_SLEEP
  } sleep_state_t;

endpackage

`default_nettype wire

/* File: core/mode_if.sv */
// Carrier between the controller and its mode decoder
`default_nettype none

interface mode_if;
  import sleep_pkg::*;

  logic    [2:0] mode;
  clk_en_t       en;
  logic          valid;

  modport dec (input mode, output en, output valid);
  modport ctl (output mode, input en, input valid);
endinterface

`default_nettype wire

/* File: core/sleep_mode_decode.sv */
// Maps a sleep mode code onto the set of clocks left running
`include "sleep_defines.svh"
`default_nettype none

module sleep_mode_decode
(
  mode_if.dec m
);
  import sleep_pkg::*;

  always_comb
  begin
    m.valid = 1'b1;
    case (m.mode)
      `MODE_IDLE:        m.en = `EN_IDLE;
      `MODE_ADC_NR:      m.en = `EN_ADC_NR;
      `MODE_PDOWN:       m.en = `EN_PDOWN;
      `MODE_PSAVE:       m.en = `EN_PSAVE;
      `MODE_STANDBY:     m.en = `EN_STANDBY;
      `MODE_EXT_STANDBY: m.en = `EN_EXT_STANDBY;
      default:
      begin
        // Unused codes keep everything running and refuse the request
        m.en    = `EN_ALL;
        m.valid = 1'b0;
      end
    endcase
  end

endmodule // sleep_mode_decode

`default_nettype wire

/* File: verification/cpu_model.sv */
// Behavioural CPU core that requests sleep and raises wake sources
`default_nettype none

module cpu_model
(
  input  wire logic       clk,
  output var  logic [2:0] mode_sel,
  output var  logic       sleep_en,
  output var  logic       sleep_req,
  output var  logic [3:0] wake_src,
  output var  logic [3:0] wake_mask
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    mode_sel  = 3'h0;
    sleep_en  = 1'b0;
    sleep_req = 1'b0;
    wake_src  = 4'h0;
    wake_mask = 4'hF;
  end

  // One-cycle sleep instruction; returns at the edge that takes it
  task automatic do_sleep(input logic [2:0] m, input logic en);
    @(posedge clk);
    mode_sel  <= m;
    sleep_en  <= en;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask

  // Left high until drop_wake; waits three edges so the two-flop synchroniser sees it
  task automatic do_wake(input int i);
    @(posedge clk);
    wake_src[i] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Waits out the synchroniser so a stale hit cannot block the next entry
  task automatic drop_wake;
    @(posedge clk);
    wake_src <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic set_mask(input logic [3:0] m);
    @(posedge clk);
    wake_mask <= m;
  endtask
endmodule // cpu_model

`default_nettype wire

/* File: verification/test_sleep_ctrl.sv */
// Self-checking testbench of the sleep controller
`include "sleep_defines.svh"
`default_nettype none

module test_sleep_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_n;
  logic [2:0] mode_sel;
  logic       sleep_en;
  logic       sleep_req;
  logic [3:0] wake_src;
  logic [3:0] wake_mask;
  logic [6:0] en;
  logic       sleeping;
  logic [2:0] sleep_mode;
  int         num_errors = 0;
  int         checked = 0;

  cpu_model i_cpu_model (.clk(clk), .mode_sel(mode_sel), .sleep_en(sleep_en), .sleep_req(sleep_req),
    .wake_src(wake_src), .wake_mask(wake_mask));

  sleep_ctrl #(.N_WAKE(4)) i_sleep_ctrl (.clk(clk), .rst_n(rst_n), .mode_sel(mode_sel),
    .sleep_en(sleep_en), .sleep_req(sleep_req), .wake_src(wake_src), .wake_mask(wake_mask),
    .cpu_clk_en(en[6]), .io_clk_en(en[5]), .sram_clk_en(en[4]), .irq_clk_en(en[3]),
    .adc_clk_en(en[2]), .osc_en(en[1]), .async_tmr_en(en[0]), .sleeping(sleeping),
    .sleep_mode(sleep_mode));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Sleep mode is only compared while asleep; awake it may hold the last code
  task automatic check(input logic [6:0] e, input logic s, input logic [2:0] m);
    checked++;
    if (en !== e || sleeping !== s || (s && sleep_mode !== m))
    begin
      num_errors++;
      $display("MISMATCH t=%0t en=%b/%b sleeping=%b mode=%h", $time, en, e, sleeping, sleep_mode);
    end
  endtask

  task automatic mode_case(input logic [2:0] m, input logic [6:0] e, input int w);
    i_cpu_model.do_sleep(m, 1'b1);
    #1 check(e, 1'b1, m);
    i_cpu_model.do_wake(w);
    #1 check(`EN_ALL, 1'b0, m);
    i_cpu_model.drop_wake();
  endtask

  task automatic t_modes;
    mode_case(`MODE_IDLE, `EN_IDLE, 0);
    mode_case(`MODE_PDOWN, `EN_PDOWN, 1);
    mode_case(`MODE_PSAVE, `EN_PSAVE, 2);
    mode_case(`MODE_ADC_NR, `EN_ADC_NR, 3);
    mode_case(`MODE_STANDBY, `EN_STANDBY, 0);
    mode_case(`MODE_EXT_STANDBY, `EN_EXT_STANDBY, 1);
    $display("test modes done");
  endtask

  task automatic t_refuse;
    i_cpu_model.do_sleep(3'h4, 1'b1);
    #1 check(`EN_ALL, 1'b0, 3'h0);
    i_cpu_model.do_sleep(3'h5, 1'b1);
    #1 check(`EN_ALL, 1'b0, 3'h0);
    i_cpu_model.do_sleep(`MODE_PDOWN, 1'b0);
    #1 check(`EN_ALL, 1'b0, 3'h0);
    $display("test refuse done");
  endtask

  task automatic t_mask;
    i_cpu_model.set_mask(4'h1);
    i_cpu_model.do_sleep(`MODE_PDOWN, 1'b1);
    i_cpu_model.do_wake(3);
    #1 check(`EN_PDOWN, 1'b1, `MODE_PDOWN);
    i_cpu_model.set_mask(4'h8);
    repeat (2) @(posedge clk);
    #1 check(`EN_ALL, 1'b0, `MODE_PDOWN);
    i_cpu_model.drop_wake();
    i_cpu_model.set_mask(4'hF);
    $display("test mask done");
  endtask

  // An enabled wake already through the synchroniser must refuse entry
  task automatic t_pending;
    i_cpu_model.do_wake(2);
    i_cpu_model.do_sleep(`MODE_IDLE, 1'b1);
    #1 check(`EN_ALL, 1'b0, `MODE_IDLE);
    i_cpu_model.drop_wake();
    i_cpu_model.do_sleep(`MODE_IDLE, 1'b1);
    #1 check(`EN_IDLE, 1'b1, `MODE_IDLE);
    i_cpu_model.do_wake(2);
    #1 check(`EN_ALL, 1'b0, `MODE_IDLE);
    i_cpu_model.drop_wake();
    $display("test pending done");
  endtask

  task automatic end_sim;
    $display("compares %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check(`EN_ALL, 1'b0, `RST_MODE);
    t_modes();
    t_refuse();
    t_mask();
    t_pending();
    end_sim();
  end
endmodule // test_sleep_ctrl

`default_nettype wire
